// [hw/ptfs_pkg.sv]
// Constants for the timer flag and status register bank
package ptfs_pkg;
  // Register byte offsets
  localparam logic [7:0] OFF_IRQ_ENABLE_SET = 8'h28;
  localparam logic [7:0] OFF_IRQ_FLAG       = 8'h2c;
  localparam logic [7:0] OFF_TIMER_STATUS   = 8'h30;
  localparam logic [7:0] OFF_IRQ_ENABLE_CLR = 8'h24;
  // Flag and enable field positions
  localparam int POS_OVF  = 0;
  localparam int POS_TRG  = 1;
  localparam int POS_CNT  = 2;
  localparam int POS_ERR  = 3;
  localparam int POS_DBG  = 11;
  localparam int POS_FLTA = 12;
  localparam int POS_CH   = 16;
  // Status field positions
  localparam int POS_STOP   = 0;
  localparam int POS_RAMP   = 1;
  localparam int POS_DHF    = 3;
  localparam int POS_SLAVE  = 4;
  localparam int POS_PATTERN_BUFFER_VALID = 5;
  localparam int POS_FIN    = 8;
  localparam int POS_FST    = 12;
  localparam int POS_CBV    = 16;
  localparam int POS_LVL    = 24;
  // Writable masks and reset values
  localparam logic [31:0] FLAG_MASK    = 32'h000ff80f;
  localparam logic [31:0] FLAG_RESET   = 32'h00000000;
  localparam logic [31:0] ENABLE_RESET = 32'h00000000;
  localparam logic [31:0] STATUS_RESET = 32'h00000001;
  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// [hw/ptfs_regs.sv]
// Flag, enable and status register bank of the control timer
// How it works
// (RULE1) Write one sets enable; zero ignored
// (RULE2) Channel flag sets after match or capture
// (RULE3) Write one clears channel flag
// (RULE4) Capture-mode value read clears channel flag
// (RULE5) Fault flags set after fault; W1C
// (RULE6) Debug fault flag sets after entry; W1C
// (RULE7) Error flag on capture overrun; W1C
// (RULE8) Counter event flag sets; W1C
// (RULE9) Retrigger flag sets; W1C
// (RULE10) Overflow flag sets; W1C
// (RULE11) Reserved bits read zero
// (RULE12) Status mirrors channel output levels
// (RULE13) Compare buffer valid: write sets, update clears
// (RULE14) Capture buffer valid: clear on value read
// (RULE15) Nonrecoverable state: set now, guarded W1C
// (RULE16) Restart before clearing; counter resumes otherwise
// (RULE17) Recoverable state: hardware resume or guarded W1C
// (RULE18) Clearing software-halt state releases counter
// (RULE19) Fault one input status follows input
// (RULE20) Other fault inputs shown at 10:8
// (RULE21) Stopped sets on stop, clears on count
// (RULE22) Period, wave, pattern buffer valid bits
// (RULE23) Debug fault status halts counter
// (RULE24) Interrupt when flag and enable both set
`timescale 1ns/10ps
`default_nettype none
module ptfs_regs (
  // Clock and reset
  input  wire  logic        aclk,
  input  wire  logic        aresetn,
  // AXI4-Lite write address and data
  input  wire  logic [7:0]  s_axi_awaddr,
  input  wire  logic        s_axi_awvalid,
  output logic              s_axi_awready,
  input  wire  logic [31:0] s_axi_wdata,
  input  wire  logic [3:0]  s_axi_wstrb,
  input  wire  logic        s_axi_wvalid,
  output logic              s_axi_wready,
  output logic [1:0]        s_axi_bresp,
  output logic              s_axi_bvalid,
  input  wire  logic        s_axi_bready,
  // AXI4-Lite read
  input  wire  logic [7:0]  s_axi_araddr,
  input  wire  logic        s_axi_arvalid,
  output logic              s_axi_arready,
  output logic [31:0]       s_axi_rdata,
  output logic [1:0]        s_axi_rresp,
  output logic              s_axi_rvalid,
  input  wire  logic        s_axi_rready,
  // Timer events, one-cycle pulses on aclk; capture mode, value read index and software-halt mode are levels
  input  wire  logic [3:0]  ch_match,
  input  wire  logic [3:0]  ch_capture,
  input  wire  logic [3:0]  ch_capture_mode,
  input  wire  logic [3:0]  ch_buffer_write,
  input  wire  logic        channel_value_read,
  input  wire  logic [1:0]  channel_value_read_idx,
  input  wire  logic        overflow_event,
  input  wire  logic        retrigger_event,
  input  wire  logic        counter_event,
  input  wire  logic        update_event,
  input  wire  logic [2:0]  aux_buffer_write,
  input  wire  logic        stop_event,
  input  wire  logic        count_step,
  input  wire  logic [1:0]  recov_resume,
  input  wire  logic [1:0]  recov_sw_halt,
  // Timer levels
  input  wire  logic [3:0]  channel_output_level,
  input  wire  logic [3:0]  fault_inputs,
  input  wire  logic        debug_halt_fault_cond,
  input  wire  logic        slave_mode,
  input  wire  logic        ramp_phase,
  // Outputs to timer and system
  output logic              counter_halt,
  output logic [1:0]        recov_release,
  output logic              irq
);
  typedef struct packed {
    logic        aw_got;
    logic        w_got;
    logic [7:0]  aw_addr;
    logic [31:0] w_data;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [1:0]  rresp;
    logic [31:0] rdata;
    logic [31:0] flag;
    logic [31:0] enable;
    logic [3:0]  cbv;
    logic [2:0]  aux_bv;
    logic [3:0]  fstate;
    logic        stop;
    logic        dbg_st;
    logic [3:0]  fin_meta;
    logic [3:0]  fin_sync;
    logic        dbg_prev;
    logic [1:0]  release_p;
    logic        irq;
  } ptfs_state_s;

  ptfs_state_s st_reg;
  ptfs_state_s st_next;

  // Fault state bits set from edges of synced inputs, one bit per input, fault one at bit 3
  function automatic logic [3:0] rise(input logic [3:0] now, input logic [3:0] was);
    rise = now & ~was;
  endfunction

  logic [3:0] fin_prev_reg;
  logic       wr_fire;
  logic       rd_fire;
  logic [31:0] status_view;
  logic [3:0]  fault_set;
  logic [3:0]  rd_clr;

  // Handshakes
  assign s_axi_awready = !st_reg.aw_got && !st_reg.bvalid;
  assign s_axi_wready  = !st_reg.w_got && !st_reg.bvalid;
  assign s_axi_arready = !st_reg.rvalid;
  assign s_axi_bvalid  = st_reg.bvalid;
  assign s_axi_bresp   = st_reg.bresp;
  assign s_axi_rvalid  = st_reg.rvalid;
  assign s_axi_rresp   = st_reg.rresp;
  assign s_axi_rdata   = st_reg.rdata;
  assign irq           = st_reg.irq;
  assign recov_release = st_reg.release_p;
  // (RULE23) debug fault halts counter
  assign counter_halt  = st_reg.dbg_st;
  assign wr_fire = st_reg.aw_got && st_reg.w_got;
  assign rd_fire = s_axi_arvalid && s_axi_arready;
  assign fault_set = rise(st_reg.fin_sync, fin_prev_reg);

  // Status register view
  always_comb
  begin
    status_view = 32'h00000000;
    // (RULE12) output level mirror
    status_view[ptfs_pkg::POS_LVL +: 4] = channel_output_level;
    status_view[ptfs_pkg::POS_CBV +: 4] = st_reg.cbv;
    status_view[ptfs_pkg::POS_FST +: 4] = st_reg.fstate;
    // (RULE19) (RULE20) fault input status
    status_view[ptfs_pkg::POS_FIN +: 4] = st_reg.fin_sync;
    status_view[ptfs_pkg::POS_PATTERN_BUFFER_VALID +: 3] = st_reg.aux_bv;
    status_view[ptfs_pkg::POS_SLAVE] = slave_mode;
    status_view[ptfs_pkg::POS_DHF] = st_reg.dbg_st;
    status_view[ptfs_pkg::POS_RAMP] = ramp_phase;
    status_view[ptfs_pkg::POS_STOP] = st_reg.stop;
  end

  // Next-state logic
  always_comb
  begin
    logic [31:0] wd;
    logic [31:0] fset;
    logic [31:0] fclr;
    logic        hit_flag;
    logic        hit_en;
    logic        hit_st;
    logic        hit_clr;
    logic [3:0]  resume4;
    wd = st_reg.w_data;
    resume4 = {2'h0, recov_resume};
    fset = 32'h0;
    fclr = 32'h0;
    hit_flag = wr_fire && st_reg.aw_addr[7:2] == ptfs_pkg::OFF_IRQ_FLAG[7:2];
    hit_en   = wr_fire && st_reg.aw_addr[7:2] == ptfs_pkg::OFF_IRQ_ENABLE_SET[7:2];
    hit_st   = wr_fire && st_reg.aw_addr[7:2] == ptfs_pkg::OFF_TIMER_STATUS[7:2];
    hit_clr  = wr_fire && st_reg.aw_addr[7:2] == ptfs_pkg::OFF_IRQ_ENABLE_CLR[7:2];
    st_next = st_reg;
    rd_clr = 4'h0;
    // Bus capture of address and data
    if (s_axi_awvalid && s_axi_awready)
    begin
      st_next.aw_got  = 1'b1;
      st_next.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      st_next.w_got  = 1'b1;
      st_next.w_data = s_axi_wdata;
    end
    if (wr_fire)
    begin
      st_next.aw_got = 1'b0;
      st_next.w_got  = 1'b0;
      st_next.bvalid = 1'b1;
      st_next.bresp  = (hit_flag || hit_en || hit_st || hit_clr) ?
                       ptfs_pkg::RESP_OKAY : ptfs_pkg::RESP_SLVERR;
    end
    if (st_reg.bvalid && s_axi_bready)
      st_next.bvalid = 1'b0;
    // Read path, reserved bits already zero
    if (rd_fire)
    begin
      st_next.rvalid = 1'b1;
      st_next.rresp  = ptfs_pkg::RESP_OKAY;
      // (RULE11) reserved bits masked off
      unique case (s_axi_araddr[7:2])
        ptfs_pkg::OFF_IRQ_FLAG[7:2]:       st_next.rdata = st_reg.flag & ptfs_pkg::FLAG_MASK;
        ptfs_pkg::OFF_IRQ_ENABLE_SET[7:2],
        ptfs_pkg::OFF_IRQ_ENABLE_CLR[7:2]: st_next.rdata = st_reg.enable & ptfs_pkg::FLAG_MASK;
        ptfs_pkg::OFF_TIMER_STATUS[7:2]:   st_next.rdata = status_view;
        default:
        begin
          st_next.rdata = 32'h0;
          st_next.rresp = ptfs_pkg::RESP_SLVERR;
        end
      endcase
    end
    else if (st_reg.rvalid && s_axi_rready)
      st_next.rvalid = 1'b0;
    if (!(&s_axi_wstrb))
      wd = wd;
    // (RULE1) enable set, zero ignored
    if (hit_en)
      st_next.enable = st_reg.enable | (wd & ptfs_pkg::FLAG_MASK);
    if (hit_clr)
      st_next.enable = st_reg.enable & ~(wd & ptfs_pkg::FLAG_MASK);
    // (RULE4) capture-mode value read
    if (channel_value_read)
      rd_clr[channel_value_read_idx] = 1'b1;
    // (RULE3) (RULE5) (RULE6) (RULE8) (RULE9) (RULE10) write-one clears
    if (hit_flag)
      fclr = wd & ptfs_pkg::FLAG_MASK;
    fclr[ptfs_pkg::POS_CH +: 4] = fclr[ptfs_pkg::POS_CH +: 4] | (rd_clr & ch_capture_mode);
    // (RULE2) channel flags after match or capture
    fset[ptfs_pkg::POS_CH +: 4] = ch_match | ch_capture;
    // (RULE7) capture onto a set flag
    fset[ptfs_pkg::POS_ERR] = |(ch_capture & st_reg.flag[ptfs_pkg::POS_CH +: 4]);
    fset[ptfs_pkg::POS_CNT] = counter_event;
    fset[ptfs_pkg::POS_TRG] = retrigger_event;
    fset[ptfs_pkg::POS_OVF] = overflow_event;
    // (RULE5) fault input flags
    fset[ptfs_pkg::POS_FLTA +: 4] = fault_set;
    fset[ptfs_pkg::POS_DBG] = debug_halt_fault_cond && !st_reg.dbg_prev;
    // Set wins over clear
    st_next.flag = ((st_reg.flag & ~fclr) | fset) & ptfs_pkg::FLAG_MASK;
    // (RULE13) (RULE14) channel buffer valid
    for (int i = 0; i < 4; i++)
    begin
      if (hit_st && wd[ptfs_pkg::POS_CBV + i] && !ch_capture_mode[i])
        st_next.cbv[i] = 1'b0;
      if (update_event && !ch_capture_mode[i])
        st_next.cbv[i] = 1'b0;
      if (rd_clr[i] && ch_capture_mode[i])
        st_next.cbv[i] = 1'b0;
      if (ch_buffer_write[i] || (ch_capture[i] && ch_capture_mode[i]))
        st_next.cbv[i] = 1'b1;
    end
    // (RULE22) period, wave, pattern buffer valid
    if (hit_st)
      st_next.aux_bv = st_reg.aux_bv & ~wd[ptfs_pkg::POS_PATTERN_BUFFER_VALID +: 3];
    if (update_event)
      st_next.aux_bv = 3'h0;
    st_next.aux_bv = st_next.aux_bv | aux_buffer_write;
    // (RULE15) (RULE17) guarded write-one clear of fault states
    st_next.release_p = 2'h0;
    for (int i = 0; i < 4; i++)
    begin
      if (hit_st && wd[ptfs_pkg::POS_FST + i] && !st_reg.fin_sync[i])
        st_next.fstate[i] = 1'b0;
      if (resume4[i])
        st_next.fstate[i] = 1'b0;
      if (fault_set[i])
        st_next.fstate[i] = 1'b1;
    end
    // (RULE18) (RULE16) release on clear, counter keeps its count
    st_next.release_p = st_reg.fstate[1:0] & ~st_next.fstate[1:0] & recov_sw_halt;
    // (RULE23) debug fault state
    if (hit_st && wd[ptfs_pkg::POS_DHF] && !debug_halt_fault_cond)
      st_next.dbg_st = 1'b0;
    if (!debug_halt_fault_cond)
      st_next.dbg_st = 1'b0;
    if (debug_halt_fault_cond && !st_reg.dbg_prev)
      st_next.dbg_st = 1'b1;
    st_next.dbg_prev = debug_halt_fault_cond;
    // (RULE21) stopped status
    if (count_step)
      st_next.stop = 1'b0;
    if (stop_event)
      st_next.stop = 1'b1;
    // Fault input synchroniser
    st_next.fin_meta = fault_inputs;
    st_next.fin_sync = st_reg.fin_meta;
    // (RULE24) interrupt request
    st_next.irq = |(st_next.flag & st_next.enable);
  end

  // State register
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      st_reg        <= '0;
      st_reg.stop   <= ptfs_pkg::STATUS_RESET[0];
      fin_prev_reg  <= 4'h0;
    end
    else
    begin
      st_reg       <= st_next;
      fin_prev_reg <= st_reg.fin_sync;
    end
  end

  // AST_SET_OVF (RULE10)
  AST_SET_OVF: assert property (@(posedge aclk) disable iff (!aresetn) // (RULE10)
    overflow_event |=> st_reg.flag[0]) else $error("overflow flag not set");
  // AST_CH_FLAG (RULE2)
  AST_CH_FLAG: assert property (@(posedge aclk) disable iff (!aresetn) // (RULE2)
    ch_match[0] |=> st_reg.flag[16]) else $error("channel flag not set");
  // AST_ERR (RULE7)
  AST_ERR: assert property (@(posedge aclk) disable iff (!aresetn) // (RULE7)
    (ch_capture[1] && st_reg.flag[17]) |=> st_reg.flag[3]) else $error("error flag missed");
  // AST_IRQ (RULE24)
  AST_IRQ: assert property (@(posedge aclk) disable iff (!aresetn) // (RULE24)
    irq == |(st_reg.flag & st_reg.enable)) else $error("irq mismatch");
  // AST_RSV (RULE11)
  AST_RSV: assert property (@(posedge aclk) disable iff (!aresetn) // (RULE11)
    s_axi_rvalid && s_axi_rresp == 2'h0 |-> s_axi_rdata[31:28] == 4'h0)
    else $error("reserved bits nonzero");
  // AST_FST (RULE15)
  AST_FST: assert property (@(posedge aclk) disable iff (!aresetn) // (RULE15)
    st_reg.fin_sync[3] |=> ##1 st_reg.fstate[3] || $past(st_reg.fstate[3]))
    else $error("fault state not held");
  // AST_STOP (RULE21)
  AST_STOP: assert property (@(posedge aclk) disable iff (!aresetn) // (RULE21)
    stop_event |=> st_reg.stop) else $error("stop not set");
  // AST_AUX (RULE22)
  AST_AUX: assert property (@(posedge aclk) disable iff (!aresetn) // (RULE22)
    aux_buffer_write[0] |=> st_reg.aux_bv[0]) else $error("buffer valid not set");
  // AST_EN (RULE1)
  AST_EN: assert property (@(posedge aclk) disable iff (!aresetn) // (RULE1)
    st_reg.enable[0] && !(wr_fire && st_reg.aw_addr == 8'h24) |=> st_reg.enable[0])
    else $error("enable lost");
  // (RULE5) fault flag sets
  AST_FLT_FLAG: assert property (@(posedge aclk) disable iff (!aresetn) // (RULE5)
    fault_set[3] |=> st_reg.flag[ptfs_pkg::POS_FLTA + 3]) else $error("fault flag not set");
  // (RULE6) debug flag sets
  AST_DBG_FLAG: assert property (@(posedge aclk) disable iff (!aresetn) // (RULE6)
    (debug_halt_fault_cond && !st_reg.dbg_prev) |=> st_reg.flag[ptfs_pkg::POS_DBG])
    else $error("debug flag not set");
  // (RULE8) counter flag sets
  AST_CNT: assert property (@(posedge aclk) disable iff (!aresetn) // (RULE8)
    counter_event |=> st_reg.flag[ptfs_pkg::POS_CNT]) else $error("counter flag not set");
  // (RULE9) retrigger flag sets
  AST_TRG: assert property (@(posedge aclk) disable iff (!aresetn) // (RULE9)
    retrigger_event |=> st_reg.flag[ptfs_pkg::POS_TRG]) else $error("retrigger flag not set");
  // (RULE3) write one clears
  AST_W1C: assert property (@(posedge aclk) disable iff (!aresetn) // (RULE3)
    wr_fire && st_reg.aw_addr == ptfs_pkg::OFF_IRQ_FLAG && st_reg.w_data[ptfs_pkg::POS_CH]
    && !ch_match[0] && !ch_capture[0] |=> !st_reg.flag[ptfs_pkg::POS_CH])
    else $error("channel flag not cleared");
  // (RULE4) value read clears
  AST_CAPRD: assert property (@(posedge aclk) disable iff (!aresetn) // (RULE4)
    channel_value_read && channel_value_read_idx == 2'h1 && ch_capture_mode[1]
    && !ch_match[1] && !ch_capture[1] |=> !st_reg.flag[ptfs_pkg::POS_CH + 1])
    else $error("capture flag not cleared by read");
  // (RULE12) level mirror read
  AST_LVL: assert property (@(posedge aclk) disable iff (!aresetn) // (RULE12)
    rd_fire && s_axi_araddr == ptfs_pkg::OFF_TIMER_STATUS
    |=> s_axi_rdata[ptfs_pkg::POS_LVL +: 4] == $past(channel_output_level))
    else $error("level mirror wrong");
  // (RULE15) guarded state clear
  AST_NRF_HOLD: assert property (@(posedge aclk) disable iff (!aresetn) // (RULE15)
    st_reg.fstate[3] && st_reg.fin_sync[3] |=> st_reg.fstate[3])
    else $error("fault state cleared early");
  // (RULE17) recoverable state sets
  AST_SET_FST: assert property (@(posedge aclk) disable iff (!aresetn) // (RULE17)
    fault_set[0] |=> st_reg.fstate[0]) else $error("recoverable state not set");
  // (RULE18) release on clear
  AST_RELEASE: assert property (@(posedge aclk) disable iff (!aresetn) // (RULE18)
    st_reg.fstate[0] && recov_sw_halt[0] && recov_resume[0] && !fault_set[0]
    |=> recov_release[0]) else $error("release pulse missing");
  // (RULE23) halt ends with debug
  AST_HALT: assert property (@(posedge aclk) disable iff (!aresetn) // (RULE23)
    !debug_halt_fault_cond |=> !counter_halt) else $error("halt not released");
endmodule
`default_nettype wire

// [test/ptfs_regs_tb_top.sv]
// Self-checking bench for the timer flag and status register bank
`timescale 1ns/10ps
`default_nettype none
module ptfs_regs_tb_top;
  // Register addresses
  localparam logic [7:0] ENC = ptfs_pkg::OFF_IRQ_ENABLE_CLR;
  localparam logic [7:0] ENS = ptfs_pkg::OFF_IRQ_ENABLE_SET;
  localparam logic [7:0] FLG = ptfs_pkg::OFF_IRQ_FLAG;
  localparam logic [7:0] STA = ptfs_pkg::OFF_TIMER_STATUS;
  // Clock, reset and bus signals
  logic             aclk = 1'h0;
  logic             aresetn = 1'h0;
  logic [7:0]       s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0]      s_axi_wdata = 32'h0;
  logic [3:0]       s_axi_wstrb = 4'hf;
  logic             s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic             s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  wire logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire logic [1:0]  s_axi_bresp, s_axi_rresp;
  wire logic [31:0] s_axi_rdata;
  // Timer levels and event pulses
  logic [3:0]       ch_capture_mode = 4'h0, channel_output_level = 4'h0, fault_inputs = 4'h0;
  logic [1:0]       channel_value_read_idx = 2'h0, recov_sw_halt = 2'h0;
  logic             debug_halt_fault_cond = 1'h0, slave_mode = 1'h0, ramp_phase = 1'h0;
  logic [23:0]      ev = 24'h0;
  wire logic [3:0]  ch_match, ch_capture, ch_buffer_write;
  wire logic [2:0]  aux_buffer_write;
  wire logic [1:0]  recov_resume, recov_release;
  wire logic        overflow_event, retrigger_event, counter_event, update_event;
  wire logic        stop_event, count_step, channel_value_read, counter_halt, irq;
  int               fail_count = 0;
  int               check_count = 0;
  int               rel_count = 0;
  // Event vector spread onto the pulse inputs
  assign {ch_match, ch_capture, ch_buffer_write, aux_buffer_write, overflow_event,
          retrigger_event, counter_event, update_event, stop_event, count_step,
          channel_value_read, recov_resume} = ev;
  // Clock generator
  always #5 aclk = ~aclk;
  // Counts release pulses seen on the recoverable fault outputs
  always @(posedge aclk)
  begin
    if (|recov_release)
      rel_count <= rel_count + 1;
  end
  // Device under test
  ptfs_regs DUT (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .ch_match(ch_match),
    .ch_capture(ch_capture), .ch_capture_mode(ch_capture_mode),
    .ch_buffer_write(ch_buffer_write), .channel_value_read(channel_value_read),
    .channel_value_read_idx(channel_value_read_idx), .overflow_event(overflow_event),
    .retrigger_event(retrigger_event), .counter_event(counter_event),
    .update_event(update_event), .aux_buffer_write(aux_buffer_write),
    .stop_event(stop_event), .count_step(count_step), .recov_resume(recov_resume),
    .recov_sw_halt(recov_sw_halt), .channel_output_level(channel_output_level),
    .fault_inputs(fault_inputs), .debug_halt_fault_cond(debug_halt_fault_cond),
    .slave_mode(slave_mode), .ramp_phase(ramp_phase), .counter_halt(counter_halt),
    .recov_release(recov_release), .irq(irq)
  );
  // Verdict and end of run
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // Value comparison
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp)
    begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // A bounded wait ran out
  task automatic hang();
    fail_count++;
    $display("[FAIL] handshake expected 1 seen 0");
    tally_and_finish();
  endtask
  // Bus write; bus sampled on each falling edge
  task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic aw_r, w_r, b_v;
    logic [1:0] rsp;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    for (int n = 0; n < 40; n++)
    begin
      @(negedge aclk);
      aw_r = s_axi_awready;
      w_r = s_axi_wready;
      b_v = s_axi_bvalid;
      rsp = s_axi_bresp;
      @(posedge aclk);
      if (aw_r) s_axi_awvalid <= 1'h0;
      if (w_r) s_axi_wvalid <= 1'h0;
      if (b_v)
      begin
        s_axi_bready <= 1'h0;
        chk("bresp", {30'h0, er}, {30'h0, rsp});
        return;
      end
    end
    hang();
  endtask
  // Bus read and compare of data and response
  task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] exp,
                     input logic [1:0] er);
    logic ar_r, r_v;
    logic [31:0] d;
    logic [1:0] rsp;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    for (int n = 0; n < 40; n++)
    begin
      @(negedge aclk);
      ar_r = s_axi_arready;
      r_v = s_axi_rvalid;
      d = s_axi_rdata;
      rsp = s_axi_rresp;
      @(posedge aclk);
      if (ar_r) s_axi_arvalid <= 1'h0;
      if (r_v)
      begin
        s_axi_rready <= 1'h0;
        chk(nm, exp, d);
        chk("rresp", {30'h0, er}, {30'h0, rsp});
        return;
      end
    end
    hang();
  endtask
  // One-cycle event pulse, then let flags settle
  task automatic fire(input logic [23:0] v);
    @(posedge aclk);
    ev <= v;
    @(posedge aclk);
    ev <= 24'h0;
    repeat (4) @(posedge aclk);
  endtask
  // Reset values, unmapped access, enable set
  task automatic t_regs();
    rdc("flag", FLG, 32'h0, ptfs_pkg::RESP_OKAY);
    rdc("status", STA, 32'h1, ptfs_pkg::RESP_OKAY);
    rdc("unmapped", 8'h40, 32'h0, ptfs_pkg::RESP_SLVERR);
    axw(8'h40, 32'h1, ptfs_pkg::RESP_SLVERR);
    axw(ENS, 32'h000ff80f, ptfs_pkg::RESP_OKAY);
    axw(ENS, 32'h0, ptfs_pkg::RESP_OKAY);
    rdc("enable", ENS, 32'h000ff80f, ptfs_pkg::RESP_OKAY);
    $display("test regs done");
  endtask
  // Event flags, partial clear and interrupt
  task automatic t_events();
    fire(24'h1001c0);
    rdc("flag", FLG, 32'h00010007, ptfs_pkg::RESP_OKAY);
    chk("irq", 32'h1, {31'h0, irq});
    axw(FLG, 32'h00000005, ptfs_pkg::RESP_OKAY);
    rdc("flag", FLG, 32'h00010002, ptfs_pkg::RESP_OKAY);
    axw(FLG, 32'h00010002, ptfs_pkg::RESP_OKAY);
    repeat (2) @(posedge aclk);
    chk("irq", 32'h0, {31'h0, irq});
    $display("test events done");
  endtask
  // Capture overrun and read clear
  task automatic t_capture();
    ch_capture_mode <= 4'h2;
    channel_value_read_idx <= 2'h1;
    fire(24'h020000);
    rdc("status", STA, 32'h00020001, ptfs_pkg::RESP_OKAY);
    fire(24'h020000);
    rdc("flag", FLG, 32'h00020008, ptfs_pkg::RESP_OKAY);
    fire(24'h000004);
    rdc("flag", FLG, 32'h00000008, ptfs_pkg::RESP_OKAY);
    rdc("status", STA, 32'h00000001, ptfs_pkg::RESP_OKAY);
    axw(FLG, 32'h00000008, ptfs_pkg::RESP_OKAY);
    ch_capture_mode <= 4'h0;
    $display("test capture done");
  endtask
  // Status mirrors, buffer valid bits and stop
  task automatic t_status();
    channel_output_level <= 4'h5;
    slave_mode <= 1'h1;
    ramp_phase <= 1'h1;
    fire(24'h000008);
    fire(24'h004a00);
    rdc("status", STA, 32'h050400b2, ptfs_pkg::RESP_OKAY);
    axw(STA, 32'h00040000, ptfs_pkg::RESP_OKAY);
    rdc("status", STA, 32'h050000b2, ptfs_pkg::RESP_OKAY);
    fire(24'h000020);
    rdc("status", STA, 32'h05000012, ptfs_pkg::RESP_OKAY);
    fire(24'h000010);
    rdc("status", STA, 32'h05000013, ptfs_pkg::RESP_OKAY);
    $display("test status done");
  endtask
  // Nonrecoverable fault with masked then enabled interrupt
  task automatic t_fault();
    axw(ENC, 32'h00008000, ptfs_pkg::RESP_OKAY);
    fault_inputs <= 4'h8;
    repeat (6) @(posedge aclk);
    rdc("status", STA, 32'h05008813, ptfs_pkg::RESP_OKAY);
    rdc("flag", FLG, 32'h00008000, ptfs_pkg::RESP_OKAY);
    chk("irq", 32'h0, {31'h0, irq});
    axw(ENS, 32'h00008000, ptfs_pkg::RESP_OKAY);
    repeat (2) @(posedge aclk);
    chk("irq", 32'h1, {31'h0, irq});
    axw(STA, 32'h00008000, ptfs_pkg::RESP_OKAY);
    rdc("status", STA, 32'h05008813, ptfs_pkg::RESP_OKAY);
    fault_inputs <= 4'h0;
    repeat (6) @(posedge aclk);
    axw(STA, 32'h00008000, ptfs_pkg::RESP_OKAY);
    rdc("status", STA, 32'h05000013, ptfs_pkg::RESP_OKAY);
    axw(FLG, 32'h00008000, ptfs_pkg::RESP_OKAY);
    rdc("flag", FLG, 32'h0, ptfs_pkg::RESP_OKAY);
    $display("test fault done");
  endtask
  // Debug halt and recoverable faults with release pulses
  task automatic t_recov();
    int r0;
    debug_halt_fault_cond <= 1'h1;
    repeat (3) @(posedge aclk);
    @(negedge aclk);
    chk("halt", 32'h1, {31'h0, counter_halt});
    axw(STA, 32'h00000008, ptfs_pkg::RESP_OKAY);
    rdc("status", STA, 32'h0500001b, ptfs_pkg::RESP_OKAY);
    rdc("flag", FLG, 32'h00000800, ptfs_pkg::RESP_OKAY);
    debug_halt_fault_cond <= 1'h0;
    repeat (2) @(posedge aclk);
    @(negedge aclk);
    chk("halt", 32'h0, {31'h0, counter_halt});
    axw(FLG, 32'h00000800, ptfs_pkg::RESP_OKAY);
    recov_sw_halt <= 2'h1;
    fault_inputs <= 4'h1;
    repeat (6) @(posedge aclk);
    rdc("status", STA, 32'h05001113, ptfs_pkg::RESP_OKAY);
    fault_inputs <= 4'h0;
    r0 = rel_count;
    fire(24'h000001);
    rdc("status", STA, 32'h05000013, ptfs_pkg::RESP_OKAY);
    chk("release", r0 + 1, rel_count);
    recov_sw_halt <= 2'h2;
    fault_inputs <= 4'h2;
    repeat (6) @(posedge aclk);
    fault_inputs <= 4'h0;
    repeat (6) @(posedge aclk);
    rdc("flag", FLG, 32'h00003000, ptfs_pkg::RESP_OKAY);
    axw(STA, 32'h00002000, ptfs_pkg::RESP_OKAY);
    rdc("status", STA, 32'h05000013, ptfs_pkg::RESP_OKAY);
    chk("release", r0 + 2, rel_count);
    axw(FLG, 32'h00003000, ptfs_pkg::RESP_OKAY);
    $display("test recov done");
  endtask
  // Main sequence
  initial
  begin
    repeat (3) @(posedge aclk);
    aresetn <= 1'h1;
    t_regs();
    t_events();
    t_capture();
    t_status();
    t_fault();
    t_recov();
    tally_and_finish();
  end
endmodule
`default_nettype wire
